/* File: core/osc_ctrl.sv */
// Oscillator control register, clock source switch and clock settings
//
// What this block does
// RQ1 - PLL output divider codes give 1..256
// RQ2 - Fast RC divider codes give 1..256
// RQ3 - Secondary ready flag follows stable oscillator
// RQ4 - Bus divisor writable only while ready flag
// RQ5 - Bus clock divided by 1,2,4,8
// RQ6 - PLL multiplier codes give 15..24
// RQ7 - Current source field reports active source
// RQ8 - New source field uses same encoding
// RQ9 - New source loaded from configuration at reset
// RQ10 - Lock bit freezes selections when monitor disabled
// RQ11 - Monitor enabled means selections never locked
// RQ12 - USB PLL lock flag follows USB PLL
// RQ13 - Main PLL lock flag follows main PLL
// RQ14 - Wait enters Sleep or Idle by bit
// RQ15 - Clock fail flag set by fail monitor
// RQ16 - Writes ignored without prior unlock sequence
// RQ17 - USB bits exist only on USB variants
// RQ18 - Unimplemented bits read as zero
// RQ19 - Switch request cleared when switch completes
// RQ20 - Secondary enable bit turns oscillator on
// RQ21 - USB fast RC bit picks USB clock
// RQ22 - Switch only after target source ready
// RQ23 - Locked selections reject switch and changes
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module osc_ctrl
   import osc_pkg::*;
#(
   parameter bit USB_VARIANT = 1'b1,
   parameter int BUS_SETTLE = OSC_BUS_DIV_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [OSC_AW-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire osc_cfg_t cfg,
   input wire osc_stat_t stat_in,
   input wire logic wait_exec,
   output osc_clk_t clk_sel,
   output logic switch_busy,
   output logic sleep_entry,
   output logic idle_entry
);
   // ------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   osc_stat_t stat_s1;
   osc_stat_t stat_s;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_s1 <= '0;
         stat_s <= '0;
      end else if (clk_en) begin
         stat_s1 <= stat_in;
         stat_s <= stat_s1;
      end
   end

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] div_factor(input logic [2:0] code);
      case (code)
         3'h0: div_factor = 9'h001;
         3'h1: div_factor = 9'h002;
         3'h2: div_factor = 9'h004;
         3'h3: div_factor = 9'h008;
         3'h4: div_factor = 9'h010;
         3'h5: div_factor = 9'h020;
         3'h6: div_factor = 9'h040;
         default: div_factor = 9'h100;
      endcase
   endfunction

   function automatic logic [4:0] mult_factor(input logic [2:0] code);
      if (code == 3'h7) begin
         mult_factor = 5'h18;
      end else begin
         mult_factor = 5'h0F + {2'h0, code};
      end
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic cfg_loaded;
   osc_cfg_t cfg_q;
   logic [2:0] pll_odiv;
   logic [2:0] frc_div;
   logic [1:0] bus_div;
   logic [2:0] pll_mult;
   logic [2:0] current_source;
   logic [2:0] new_source;
   logic selection_lock;
   logic sleep_on_wait;
   logic clock_fail_flag;
   logic usb_fast_rc_select;
   logic secondary_osc_enable;
   logic switch_request;
   logic [7:0] settle_cnt;
   osc_unlock_t unlock_st;
   logic [31:0] word;

   wire logic unlocked = (unlock_st == OSC_OPEN);
   wire logic ctrl_wr = clk_en && wr && (addr == OSC_CTRL_IDX);
   wire logic key_wr = clk_en && wr && (addr == OSC_KEY_IDX);
   wire logic ctrl_ok = ctrl_wr && unlocked && cfg_loaded; // see RQ16
   wire logic sel_locked = selection_lock && cfg_q.switch_monitor[1];
   wire logic bus_divisor_ready = (settle_cnt == 8'h00);
   wire logic sec_ready = stat_s.sosc_running && secondary_osc_enable;
   wire logic usb_locked = USB_VARIANT && stat_s.usb_pll_lock;
   logic src_ready;
   wire logic switch_done = switch_request && src_ready;
   wire logic switch_set = ctrl_ok && !sel_locked && wdata[OSC_SWITCH_REQUEST_BIT];

   // ------------------------------------------------------------
   // Unlock sequence
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_st <= OSC_SHUT;
      end else if (clk_en && wr) begin
         case (unlock_st)
            OSC_SHUT: begin
               unlock_st <= (key_wr && wdata == OSC_KEY1) ? OSC_KEYED : OSC_SHUT;
            end
            OSC_KEYED: begin
               unlock_st <= (key_wr && wdata == OSC_KEY2) ? OSC_OPEN : OSC_SHUT;
            end
            default: begin
               unlock_st <= OSC_SHUT; // see RQ16
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Configuration capture after reset release
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_loaded <= 1'b0;
         cfg_q <= '0;
      end else if (clk_en && !cfg_loaded) begin
         cfg_loaded <= 1'b1;
         cfg_q <= cfg;
      end
   end

   // ------------------------------------------------------------
   // Clock and PLL selections
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pll_odiv <= '0;
         pll_mult <= '0;
         new_source <= '0;
         selection_lock <= 1'b0;
      end else if (clk_en && !cfg_loaded) begin
         pll_odiv <= cfg.pll_odiv;
         pll_mult <= cfg.pll_mult;
         new_source <= cfg.initial_source; // see RQ9
      end else if (ctrl_ok) begin
         selection_lock <= wdata[OSC_LOCK_BIT];
         if (!sel_locked) begin // see RQ10 see RQ11 see RQ23
            pll_odiv <= wdata[OSC_PLL_OUTPUT_DIVIDER_LSB +: 3];
            pll_mult <= wdata[OSC_PLL_MULTIPLIER_LSB +: 3];
            new_source <= wdata[OSC_NEW_SOURCE_LSB +: 3]; // see RQ8
         end
      end
   end

   // ------------------------------------------------------------
   // Plain control bits
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frc_div <= OSC_FAST_RC_DIVIDER_RST; // see RQ2
         sleep_on_wait <= 1'b0;
         usb_fast_rc_select <= 1'b0;
         secondary_osc_enable <= 1'b0;
      end else if (clk_en && !cfg_loaded) begin
         secondary_osc_enable <= cfg.sosc_en;
      end else if (ctrl_ok) begin
         frc_div <= wdata[OSC_FAST_RC_DIVIDER_LSB +: 3];
         sleep_on_wait <= wdata[OSC_SLEEP_ON_WAIT_BIT];
         usb_fast_rc_select <= USB_VARIANT && wdata[OSC_UFRC_BIT]; // see RQ17
         secondary_osc_enable <= wdata[OSC_SECONDARY_OSC_ENABLE_BIT]; // see RQ20
      end
   end

   // ------------------------------------------------------------
   // Peripheral bus divisor and its ready flag
   // ------------------------------------------------------------
   wire logic bus_wr = ctrl_ok && bus_divisor_ready &&
      (wdata[OSC_BUSDIV_LSB +: 2] != bus_div);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_div <= OSC_BUSDIV_RST; // see RQ5
         settle_cnt <= 8'h00;
      end else if (clk_en && !cfg_loaded) begin
         bus_div <= cfg.bus_div;
      end else if (bus_wr) begin
         bus_div <= wdata[OSC_BUSDIV_LSB +: 2]; // see RQ4
         settle_cnt <= 8'(BUS_SETTLE);
      end else if (clk_en && !bus_divisor_ready) begin
         settle_cnt <= settle_cnt - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Clock switch
   // ------------------------------------------------------------
   always_comb begin
      case (new_source)
         OSC_SRC_FAST_RC_VIA_PLL: src_ready = stat_s.main_pll_lock;
         OSC_SRC_PRI: src_ready = stat_s.primary_ready;
         OSC_SRC_PRIPLL: src_ready = stat_s.primary_ready && stat_s.main_pll_lock;
         OSC_SRC_SEC: src_ready = sec_ready;
         default: src_ready = 1'b1;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         switch_request <= 1'b0;
         current_source <= '0;
      end else if (clk_en && !cfg_loaded) begin
         current_source <= cfg.initial_source;
      end else if (clk_en) begin
         if (switch_done && !sel_locked) begin
            current_source <= new_source; // see RQ22 see RQ7
         end
         if (switch_set) begin
            switch_request <= 1'b1;
         end else if (switch_done || sel_locked) begin
            switch_request <= 1'b0; // see RQ19
         end
      end
   end

   // ------------------------------------------------------------
   // Clock fail flag
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clock_fail_flag <= 1'b0;
      end else if (clk_en) begin
         if (stat_s.clock_fail) begin
            clock_fail_flag <= 1'b1; // see RQ15
         end else if (ctrl_ok && !wdata[OSC_CF_BIT]) begin
            clock_fail_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Wait handling and clock settings out
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_entry <= 1'b0;
         idle_entry <= 1'b0;
      end else if (clk_en) begin
         sleep_entry <= wait_exec && sleep_on_wait; // see RQ14
         idle_entry <= wait_exec && !sleep_on_wait;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sel <= '0;
         switch_busy <= 1'b0;
      end else if (clk_en) begin
         clk_sel.source <= current_source;
         clk_sel.pll_mult_factor <= mult_factor(pll_mult); // see RQ6
         clk_sel.pll_out_div_factor <= div_factor(pll_odiv); // see RQ1
         clk_sel.frc_div_factor <= div_factor(frc_div); // see RQ2
         clk_sel.bus_div_factor <= 4'h1 << bus_div; // see RQ5
         clk_sel.sosc_on <= secondary_osc_enable; // see RQ20
         clk_sel.usb_clk_from_frc <= usb_fast_rc_select; // see RQ21
         switch_busy <= switch_request;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      word = 32'h00000000; // see RQ18
      word[OSC_PLL_OUTPUT_DIVIDER_LSB +: 3] = pll_odiv;
      word[OSC_FAST_RC_DIVIDER_LSB +: 3] = frc_div;
      word[OSC_SECONDARY_OSC_READY_BIT] = sec_ready; // see RQ3
      word[OSC_BUSRDY_BIT] = bus_divisor_ready; // see RQ4
      word[OSC_BUSDIV_LSB +: 2] = bus_div;
      word[OSC_PLL_MULTIPLIER_LSB +: 3] = pll_mult;
      word[OSC_CURRENT_SOURCE_LSB +: 3] = current_source; // see RQ7
      word[OSC_NEW_SOURCE_LSB +: 3] = new_source;
      word[OSC_LOCK_BIT] = selection_lock;
      word[OSC_USB_PLL_LOCKED_BIT] = usb_locked; // see RQ12 see RQ17
      word[OSC_MAIN_PLL_LOCKED_BIT] = stat_s.main_pll_lock; // see RQ13
      word[OSC_SLEEP_ON_WAIT_BIT] = sleep_on_wait;
      word[OSC_CF_BIT] = clock_fail_flag;
      word[OSC_UFRC_BIT] = usb_fast_rc_select;
      word[OSC_SECONDARY_OSC_ENABLE_BIT] = secondary_osc_enable;
      word[OSC_SWITCH_REQUEST_BIT] = switch_request;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
      end else if (clk_en) begin
         if (rd && addr == OSC_CTRL_IDX) begin
            rdata <= word;
         end else begin
            rdata <= 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence two_en_s;
      rst_n && clk_en ##1 clk_en;
   endsequence

   sequence blocked_wr_s;
      ctrl_wr && !unlocked;
   endsequence

   sequence switch_fire_s;
      clk_en && switch_done && !sel_locked && !switch_set;
   endsequence

   reserved_zero_a: assert property (clk_en && rd |=> // see RQ18
      rdata[31:30] == 2'h0 && !rdata[23] && !rdata[15] && !rdata[11])
      else $error("unimplemented bit read as one");

   blocked_write_a: assert property (blocked_wr_s |=> // see RQ16
      $stable(pll_mult) && $stable(new_source) && $stable(frc_div) && $stable(sleep_on_wait))
      else $error("write taken without unlock");

   locked_hold_a: assert property (clk_en && sel_locked |=> // see RQ23
      $stable(new_source) && $stable(pll_mult) && $stable(pll_odiv) && $stable(current_source))
      else $error("locked selection changed");

   monitor_unlock_a: assert property (ctrl_ok && !cfg_q.switch_monitor[1] |=> // see RQ11
      pll_mult == $past(wdata[OSC_PLL_MULTIPLIER_LSB +: 3]))
      else $error("selection locked with monitor enabled");

   switch_done_a: assert property (switch_fire_s |=> // see RQ22
      current_source == $past(new_source) && !switch_request)
      else $error("switch did not complete");

   switch_wait_a: assert property (clk_en && switch_request && !src_ready |=> // see RQ22
      $stable(current_source))
      else $error("source changed before ready");

   sosc_sync_a: assert property (two_en_s |=> // see RQ3
      stat_s.sosc_running == $past(stat_in.sosc_running, 2))
      else $error("secondary ready not two cycles behind pin");

   fail_sticky_a: assert property (clk_en && stat_s.clock_fail |=> clock_fail_flag) // see RQ15
      else $error("clock fail not flagged");

   bus_settle_a: assert property (clk_en && bus_wr |=> // see RQ4
      !bus_divisor_ready ##1 (!clk_en || settle_cnt == 8'(BUS_SETTLE - 1)))
      else $error("bus divisor ready not held low");

   wait_mode_a: assert property (clk_en && wait_exec |=> // see RQ14
      (sleep_entry == $past(sleep_on_wait)) && (idle_entry == !$past(sleep_on_wait)))
      else $error("wrong low power mode");

   odiv_out_a: assert property (clk_en && cfg_loaded && pll_odiv == 3'h7 |=> // see RQ1
      clk_sel.pll_out_div_factor == 9'h100)
      else $error("pll output divide by 256 wrong");

   mult_out_a: assert property (clk_en && cfg_loaded && pll_mult == 3'h0 |=> // see RQ6
      clk_sel.pll_mult_factor == 5'h0F)
      else $error("pll multiply by 15 wrong");

   usb_absent_a: assert property (!USB_VARIANT |-> !word[OSC_USB_PLL_LOCKED_BIT] && // see RQ17
      !word[OSC_UFRC_BIT])
      else $error("usb bit present on plain variant");
endmodule

/* File: core/osc_pkg.sv */
// Constants, field layout and carrier types for the oscillator control block
package osc_pkg;
   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   localparam int OSC_AW = 4;
   localparam logic [3:0] OSC_CTRL_IDX = 4'h0;
   localparam logic [3:0] OSC_KEY_IDX = 4'h1;
   // Arbitrary unlock key values
   localparam logic [31:0] OSC_KEY1 = 32'hA5A50F0F;
   localparam logic [31:0] OSC_KEY2 = 32'h5A5AF0F0;
   // ------------------------------------------------------------
   // Field positions of the control register
   // ------------------------------------------------------------
   localparam int OSC_PLL_OUTPUT_DIVIDER_LSB = 27;
   localparam int OSC_FAST_RC_DIVIDER_LSB = 24;
   localparam int OSC_SECONDARY_OSC_READY_BIT = 22;
   localparam int OSC_BUSRDY_BIT = 21;
   localparam int OSC_BUSDIV_LSB = 19;
   localparam int OSC_PLL_MULTIPLIER_LSB = 16;
   localparam int OSC_CURRENT_SOURCE_LSB = 12;
   localparam int OSC_NEW_SOURCE_LSB = 8;
   localparam int OSC_LOCK_BIT = 7;
   localparam int OSC_USB_PLL_LOCKED_BIT = 6;
   localparam int OSC_MAIN_PLL_LOCKED_BIT = 5;
   localparam int OSC_SLEEP_ON_WAIT_BIT = 4;
   localparam int OSC_CF_BIT = 3;
   localparam int OSC_UFRC_BIT = 2;
   localparam int OSC_SECONDARY_OSC_ENABLE_BIT = 1;
   localparam int OSC_SWITCH_REQUEST_BIT = 0;
   // ------------------------------------------------------------
   // Fixed reset values
   // ------------------------------------------------------------
   localparam logic [2:0] OSC_FAST_RC_DIVIDER_RST = 3'h1;
   localparam logic [1:0] OSC_BUSDIV_RST = 2'h3;
   // ------------------------------------------------------------
   // Clock source codes
   // ------------------------------------------------------------
   localparam logic [2:0] OSC_SRC_FRC = 3'h0;
   localparam logic [2:0] OSC_SRC_FAST_RC_VIA_PLL = 3'h1;
   localparam logic [2:0] OSC_SRC_PRI = 3'h2;
   localparam logic [2:0] OSC_SRC_PRIPLL = 3'h3;
   localparam logic [2:0] OSC_SRC_SEC = 3'h4;
   localparam logic [2:0] OSC_SRC_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [2:0] OSC_SRC_FRC16 = 3'h6;
   localparam logic [2:0] OSC_SRC_FAST_RC_DIVIDER = 3'h7;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int OSC_CLK_MHZ = 10;
   localparam int OSC_BUS_DIV_SETTLE_NS = 800;
   localparam int OSC_BUS_DIV_CYC = (OSC_BUS_DIV_SETTLE_NS * OSC_CLK_MHZ + 999) / 1000;
   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] initial_source;
      logic [1:0] switch_monitor;
      logic [2:0] pll_odiv;
      logic [2:0] pll_mult;
      logic [1:0] bus_div;
      logic sosc_en;
   } osc_cfg_t;
   typedef struct packed {
      logic sosc_running;
      logic main_pll_lock;
      logic usb_pll_lock;
      logic primary_ready;
      logic clock_fail;
   } osc_stat_t;
   typedef struct packed {
      logic [2:0] source;
      logic [4:0] pll_mult_factor;
      logic [8:0] pll_out_div_factor;
      logic [8:0] frc_div_factor;
      logic [3:0] bus_div_factor;
      logic sosc_on;
      logic usb_clk_from_frc;
   } osc_clk_t;
   typedef enum logic [1:0] {OSC_SHUT, OSC_KEYED, OSC_OPEN} osc_unlock_t;
endpackage

/* File: tb/osc_ctrl_test.sv */
// Self-checking bench for the oscillator control block
`timescale 1ns/10ps
module osc_ctrl_test;
   import osc_pkg::*;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   localparam int BS = 8;
   logic mclk, nrst, clk_en, wr, rd, wait_exec, switch_busy, sleep_entry, idle_entry;
   logic [OSC_AW-1:0] addr;
   logic [31:0] wdata, rdata;
   osc_cfg_t cfg;
   osc_stat_t stat_in;
   osc_clk_t clk_sel;
   logic [31:0] q_rd[$];
   logic [1:0] q_wt[$];
   logic rd_seen, wt_seen;
   int fails, n_tests;
   logic [2:0] m_odiv, m_frc, m_mult, m_current_source, m_new_source;
   logic [1:0] m_bus;
   logic m_rdy, m_lock, m_slp, m_cf, m_sosc, m_osw, m_ufrc;

   osc_ctrl #(.USB_VARIANT(1'b1), .BUS_SETTLE(BS)) dut_u (.mclk(mclk), .nrst(nrst),
      .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .cfg(cfg), .stat_in(stat_in), .wait_exec(wait_exec), .clk_sel(clk_sel),
      .switch_busy(switch_busy), .sleep_entry(sleep_entry), .idle_entry(idle_entry));

   always #50 mclk = ~mclk;

   // ------------------------------------------------------------
   // Expected values
   // ------------------------------------------------------------
   function automatic logic [31:0] mk(input logic osw);
      mk = {2'h0, m_odiv, m_frc, 3'h0, m_bus, m_mult, 5'h0, m_new_source, m_lock, 2'h0, m_slp,
         1'b1, m_ufrc, m_sosc, osw};
   endfunction
   function automatic logic [31:0] ex();
      ex = {2'h0, m_odiv, m_frc, 1'b0, stat_in.sosc_running & m_sosc, m_rdy, m_bus, m_mult,
         1'b0, m_current_source, 1'b0, m_new_source, m_lock, stat_in.usb_pll_lock, stat_in.main_pll_lock,
         m_slp, m_cf, m_ufrc, m_sosc, m_osw};
   endfunction
   function automatic logic [8:0] dv(input logic [2:0] c);
      dv = (c == 3'h7) ? 9'h100 : 9'h001 << c;
   endfunction
   task automatic init_m();
      m_odiv = cfg.pll_odiv; m_frc = OSC_FAST_RC_DIVIDER_RST; m_mult = cfg.pll_mult;
      m_bus = cfg.bus_div; m_current_source = cfg.initial_source; m_new_source = cfg.initial_source;
      m_sosc = cfg.sosc_en; m_rdy = 1'b1; m_lock = 1'b0; m_slp = 1'b0;
      m_cf = 1'b0; m_osw = 1'b0;
      m_ufrc = 1'b0;
   endtask

   // ------------------------------------------------------------
   // Compare and bus tasks
   // ------------------------------------------------------------
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pulse(input logic [1:0] got, input logic [1:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected pulse at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic issue(input logic [3:0] a, input logic [31:0] d, input logic w,
      input logic r);
      addr <= a; wdata <= d; wr <= w; rd <= r;
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0; rd <= 1'b0; wait_exec <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic cw(input logic [31:0] d);
      issue(OSC_KEY_IDX, OSC_KEY1, 1'b1, 1'b0);
      issue(OSC_KEY_IDX, OSC_KEY2, 1'b1, 1'b0);
      issue(OSC_CTRL_IDX, d, 1'b1, 1'b0);
      idle(1);
   endtask
   task automatic rdq(input logic [3:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      issue(a, 32'h0, 1'b0, 1'b1);
      idle(1);
   endtask
   task automatic wt(input logic [1:0] e);
      q_wt.push_back(e);
      wait_exec <= 1'b1;
      @(posedge mclk);
      idle(1);
   endtask
   task end_sim;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Result watcher and watchdog
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      if (rd_seen) begin
         cmp_word(rdata, q_rd.pop_front());
      end
      if (wt_seen) begin
         cmp_pulse({sleep_entry, idle_entry}, q_wt.pop_front());
      end
      rd_seen = rd;
      wt_seen = wait_exec;
   end
   initial begin
      repeat (6000) @(posedge mclk);
      fails++;
      end_sim();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0; nrst = 1'b0; clk_en = 1'b1; wr = 1'b0; rd = 1'b0; wait_exec = 1'b0;
      addr = '0; wdata = 32'h0; stat_in = '0; fails = 0; n_tests = 0;
      rd_seen = 1'b0; wt_seen = 1'b0;
      void'($urandom(32'h7232));
      cfg = osc_cfg_t'(14'($urandom));
      cfg.switch_monitor = 2'h2;
      cfg.sosc_en = 1'b1;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      idle(12);
      init_m();
      rdq(OSC_CTRL_IDX, ex());
      rdq(OSC_KEY_IDX, 32'h0);
      rdq(4'h9, 32'h0);
      issue(OSC_CTRL_IDX, 32'hFFFFFFFF, 1'b1, 1'b0);
      idle(2);
      rdq(OSC_CTRL_IDX, ex());
      for (int c = 0; c < 8; c++) begin
         m_odiv = 3'(c); m_frc = 3'(c); m_mult = 3'(c); m_bus = 2'(c);
         cw(mk(1'b0));
         idle(12);
         cmp_word(32'(clk_sel.pll_out_div_factor), 32'(dv(m_odiv)));
         cmp_word(32'(clk_sel.frc_div_factor), 32'(dv(m_frc)));
         cmp_word(32'(clk_sel.pll_mult_factor), (c == 7) ? 32'h18 : 32'(32'hF + c));
         cmp_word(32'(clk_sel.bus_div_factor), 32'h1 << m_bus);
         rdq(OSC_CTRL_IDX, ex());
      end
      m_bus = m_bus + 2'h1;
      cw(mk(1'b0));
      m_rdy = 1'b0;
      rdq(OSC_CTRL_IDX, ex());
      cw(mk(1'b0) ^ 32'h00180000);
      idle(12);
      m_rdy = 1'b1;
      rdq(OSC_CTRL_IDX, ex());
      stat_in <= 5'h1D;
      m_cf = 1'b1;
      idle(4);
      rdq(OSC_CTRL_IDX, ex());
      stat_in <= 5'h1C;
      idle(4);
      m_cf = 1'b0;
      m_sosc = 1'b0;
      cw(mk(1'b0) & ~32'h8);
      idle(4);
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(clk_sel.sosc_on), 32'h0);
      m_sosc = 1'b1;
      cw(mk(1'b0));
      idle(4);
      cmp_word(32'(clk_sel.sosc_on), 32'h1);
      m_ufrc = 1'b1;
      cw(mk(1'b0));
      idle(4);
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(clk_sel.usb_clk_from_frc), 32'h1);
      wt(2'h1);
      m_slp = 1'b1;
      cw(mk(1'b0));
      wt(2'h2);
      m_new_source = OSC_SRC_PRI;
      m_osw = 1'b1;
      cw(mk(1'b1));
      idle(6);
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(switch_busy), 32'h1);
      stat_in <= 5'h1E;
      idle(6);
      m_current_source = m_new_source;
      m_osw = 1'b0;
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(clk_sel.source), 32'(m_current_source));
      for (int s = 0; s < 8; s++) begin
         m_new_source = 3'(s);
         cw(mk(1'b1));
         idle(8);
         m_current_source = m_new_source;
         rdq(OSC_CTRL_IDX, ex());
         cmp_word(32'(clk_sel.source), 32'(s));
      end
      m_lock = 1'b1;
      cw(mk(1'b0));
      cw(mk(1'b1) ^ 32'h00070700);
      idle(8);
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(clk_sel.source), 32'(m_current_source));
      m_lock = 1'b0;
      cw(mk(1'b0));
      cfg <= '{initial_source: 3'($urandom), switch_monitor: 2'h1, pll_odiv: 3'($urandom),
         pll_mult: 3'($urandom), bus_div: 2'($urandom), sosc_en: 1'b1};
      nrst <= 1'b0;
      idle(4);
      nrst <= 1'b1;
      idle(12);
      init_m();
      rdq(OSC_CTRL_IDX, ex());
      m_lock = 1'b1;
      cw(mk(1'b0));
      m_mult = ~m_mult;
      cw(mk(1'b0));
      idle(4);
      rdq(OSC_CTRL_IDX, ex());
      cmp_word(32'(clk_sel.pll_mult_factor),
         (m_mult == 3'h7) ? 32'h18 : 32'(32'hF + m_mult));
      end_sim();
   end
endmodule
